// >>> rtl/eeprom_config_loader.sv
// configuration loader: reads eeprom words after reset and
// drives the per-port configuration fields of the switch.
// assumes an eeprom reader that answers each held request
// with a one-cycle ee_ack carrying ee_rdata.
`timescale 1ns/10ps

// Contract
// - word 00h must hold 1516h; it marks eeprom contents valid.
// - word 06h bit 0 loads extended vc count, all ports.
// - word 06h bits 3:1 load l0s exit latency, all ports.
// - word 06h bits 6:4 load l1 exit latency, all ports.
// - word 06h bit 7 loads clock pm capability, all ports.
// - word 06h bit 8 selects no ordering across egress ports.
// - word 06h bit 9 selects no ordering across completion tags.
// - word 06h bit 10 selects store and forward on port 0.
// - word 06h bits 12:11 give port 0 cut-through threshold.
// - word 06h bit 13 selects port 0 arbiter mode.
// - word 06h bit 14 selects port 0 credit update mode.
// - word 06h bit 15 limits store and forward to non-posted.
// - word 0Ch bits 1:0 load max payload size, all ports.
// - word 0Ch bits 3:2 load aspm support level, all ports.
// - word 0Ch bit 4 flags role-based error reporting, all ports.
// - word 0Ch bit 5 disables msi capability, all ports.
// - word 0Ch bit 6 disables compliance parity, all ports.
// - word 0Ch bit 7 disables power management cap, all ports.
// - word 0Ch bit 8 lets posted pass non-posted, all ports.
// - word 06h high byte only port 0; the rest all ports.
module eeprom_config_loader
   import eeprom_loader_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,

   // eeprom word reader
   output logic ee_req,
   output logic [7:0] ee_addr,
   input wire logic ee_ack,
   input wire logic [15:0] ee_rdata,

   // configuration fields
   output id_cfg_t ids,
   output switch_mode_t port0_mode,
   output port_cfg_t port_cfg [NUM_PORTS],
   output logic cfg_access_enable,

   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,

   // read channels
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // ----------------------------------------
   // load sequencer
   // ----------------------------------------
   typedef enum logic [1:0] {
      st_issue,
      st_wait,
      st_done
   } load_state_t;

   load_state_t state;

   logic sig_ok;
   logic sig_bad;

   logic skip_load;
   logic reload_req;

   logic [15:0] raw_mode;
   logic [15:0] raw_cap;

   // decode of the word just answered
   wire took = (state == st_wait) && ee_ack;
   wire at_sig = (ee_addr == EE_ADDR_SIG);
   wire sig_match = (ee_rdata == EE_SIGNATURE);
   wire at_last = (ee_addr == EE_ADDR_CAP);

   // one strobe per word slot
   wire take_vid = took && (ee_addr == EE_ADDR_VID);
   wire take_did = took && (ee_addr == EE_ADDR_DID);
   wire take_mode = took && (ee_addr == EE_ADDR_MODE);
   wire take_svid = took && (ee_addr == EE_ADDR_SVID);
   wire take_sid = took && (ee_addr == EE_ADDR_SID);
   wire take_cap = took && (ee_addr == EE_ADDR_CAP);

   wire bad_sig = took && at_sig && !sig_match;
   wire restart = (state == st_done) && reload_req;

   wire [7:0] next_addr = 8'(ee_addr + EE_ADDR_STEP);

   // state and request handshake
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state <= st_issue;
         ee_req <= 1'b0;
         ee_addr <= EE_ADDR_SIG;
      end else begin
         case (state)
            st_issue: begin
               ee_req <= 1'b1;
               state <= st_wait;
            end

            st_wait: begin
               if (ee_ack) begin
                  ee_req <= 1'b0;
                  if (bad_sig || at_last) begin
                     state <= st_done;
                  end else begin
                     ee_addr <= next_addr;
                     state <= st_issue;
                  end
               end
            end

            st_done: begin
               if (reload_req) begin
                  ee_addr <= EE_ADDR_SIG;
                  state <= skip_load ? st_done : st_issue;
               end
            end

            default: begin
               state <= st_done;
               ee_req <= 1'b0;
            end
         endcase
      end
   end

   // config access held off until loading ends
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_access_enable <= 1'b0;
      end else if (restart && !skip_load) begin
         cfg_access_enable <= 1'b0;
      end else if (took && (bad_sig || at_last)) begin
         cfg_access_enable <= 1'b1;
      end
   end

   // signature verdict
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         sig_ok <= 1'b0;
         sig_bad <= 1'b0;
      end else if (took && at_sig) begin
         sig_ok <= sig_match;
         sig_bad <= !sig_match;
      end
   end

   // ----------------------------------------
   // identification words
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         ids <= DEF_IDS;
      end else begin
         if (take_vid) ids.vendor_id <= ee_rdata;
         if (take_did) ids.device_id <= ee_rdata;
         if (take_svid) ids.subsys_vendor_id <= ee_rdata;
         if (take_sid) ids.subsys_id <= ee_rdata;
      end
   end

   // raw copies for software readback
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         raw_mode <= 16'h0000;
         raw_cap <= 16'h0000;
      end else begin
         if (take_mode) raw_mode <= ee_rdata;
         if (take_cap) raw_cap <= ee_rdata;
      end
   end

   // ----------------------------------------
   // port 0 switch mode, high byte of word 06h
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn || restart) begin
         port0_mode <= DEF_SWITCH_MODE;
      end else if (take_mode) begin
         port0_mode.no_order_egress <= ee_rdata[W06_NO_ORD_EGR];
         port0_mode.no_order_cpl_tag <= ee_rdata[W06_NO_ORD_TAG];
         port0_mode.store_forward <= ee_rdata[W06_SF];
         port0_mode.cut_through_threshold <= ee_rdata[W06_CT_LO +: 2];
         port0_mode.arbiter_mode <= ee_rdata[W06_ARB];
         port0_mode.credit_update_mode <= ee_rdata[W06_CREDIT];
         port0_mode.nonposted_sf_only <= ee_rdata[W06_NP_SF];
      end
   end

   // ----------------------------------------
   // per-port fields, replicated on all ports
   // ----------------------------------------
   for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
      always_ff @(posedge aclk) begin
         if (!aresetn || restart) begin
            port_cfg[p] <= DEF_PORT_CFG;
         end else if (take_mode) begin
            port_cfg[p].ext_vc_count <= ee_rdata[W06_EXT_VC];
            port_cfg[p].l0s_exit_latency <= ee_rdata[W06_L0S_LO +: 3];
            port_cfg[p].l1_exit_latency <= ee_rdata[W06_L1_LO +: 3];
            port_cfg[p].clock_pm_cap <= ee_rdata[W06_CLK_PM];
         end else if (take_cap) begin
            port_cfg[p].max_payload_supported <= ee_rdata[W0C_MPS_LO +: 2];
            port_cfg[p].aspm_support <= ee_rdata[W0C_ASPM_LO +: 2];
            port_cfg[p].role_based_err_rpt <= ee_rdata[W0C_RBER];
            port_cfg[p].msi_cap_disable <= ee_rdata[W0C_MSI_DIS];
            port_cfg[p].compliance_parity_disable <= ee_rdata[W0C_PAR_DIS];
            port_cfg[p].pm_cap_disable <= ee_rdata[W0C_PM_DIS];
            port_cfg[p].posted_pass_nonposted_enable <= ee_rdata[W0C_PPNP];
         end
      end
   end

   // ----------------------------------------
   // axi4-lite write channel
   // ----------------------------------------
   logic aw_full;
   logic w_full;

   logic [7:0] aw_addr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   wire aw_hs = s_axi_awvalid && s_axi_awready;
   wire w_hs = s_axi_wvalid && s_axi_wready;
   wire b_hs = s_axi_bvalid && s_axi_bready;

   // held pair, no response owed
   wire do_write = aw_full && w_full && !s_axi_bvalid;

   // write address decode
   wire [7:0] wr_word = aw_addr_q & ADDR_WORD_MASK;
   wire wr_ctrl = (wr_word == REG_CTRL);
   wire wr_mapped = wr_ctrl || (wr_word == REG_STATUS) ||
                    (wr_word == REG_IDS) || (wr_word == REG_SUBSYS) ||
                    (wr_word == REG_RAW);

   wire ctrl_wr = do_write && wr_ctrl && wstrb_q[0];

   // address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         aw_addr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_full <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr_q <= s_axi_awaddr;
         end else if (do_write) begin
            aw_full <= 1'b0;
         end else if (!aw_full && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end

         if (w_hs) begin
            w_full <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_write) begin
            w_full <= 1'b0;
         end else if (!w_full && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
      end
   end

   // write response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (b_hs) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   // control register: skip bit and reload pulse
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         skip_load <= CTRL_SKIP_RESET;
         reload_req <= 1'b0;
      end else begin
         reload_req <= ctrl_wr && wdata_q[CTRL_RELOAD];
         if (ctrl_wr) skip_load <= wdata_q[CTRL_SKIP];
      end
   end

   // ----------------------------------------
   // axi4-lite read channel
   // ----------------------------------------
   wire ar_hs = s_axi_arvalid && s_axi_arready;
   wire r_hs = s_axi_rvalid && s_axi_rready;

   wire [7:0] rd_word = s_axi_araddr & ADDR_WORD_MASK;

   // register words as read back
   wire [31:0] rd_ctrl = {30'h0000_0000, skip_load, 1'b0};
   wire [31:0] rd_status = {28'h000_0000, state != st_done,
                            sig_bad, sig_ok, cfg_access_enable};
   wire [31:0] rd_ids = {ids.device_id, ids.vendor_id};
   wire [31:0] rd_subsys = {ids.subsys_id, ids.subsys_vendor_id};
   wire [31:0] rd_raw = {raw_cap, raw_mode};

   wire rd_hit_ctrl = (rd_word == REG_CTRL);
   wire rd_hit_status = (rd_word == REG_STATUS);
   wire rd_hit_ids = (rd_word == REG_IDS);
   wire rd_hit_subsys = (rd_word == REG_SUBSYS);
   wire rd_hit_raw = (rd_word == REG_RAW);
   wire rd_mapped = rd_hit_ctrl || rd_hit_status || rd_hit_ids ||
                    rd_hit_subsys || rd_hit_raw;

   // data select
   wire [31:0] rd_mux = rd_hit_ctrl ? rd_ctrl :
                        rd_hit_status ? rd_status :
                        rd_hit_ids ? rd_ids :
                        rd_hit_subsys ? rd_subsys :
                        rd_hit_raw ? rd_raw : 32'h0000_0000;

   // one read under way at a time
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= RESP_OKAY;
      end else if (ar_hs) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (r_hs) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// >>> rtl/eeprom_loader_pkg.sv
// package for the configuration loader: word map, field
// positions, register map, defaults and the carrier structs.
// assumes a 16-bit word eeprom and a three-port switch.
package eeprom_loader_pkg;

   // ----------------------------------------
   // eeprom word addresses
   // ----------------------------------------
   localparam logic [15:0] EE_SIGNATURE = 16'h1516;
   localparam logic [7:0] EE_ADDR_SIG = 8'h00;
   localparam logic [7:0] EE_ADDR_VID = 8'h02;
   localparam logic [7:0] EE_ADDR_DID = 8'h04;
   localparam logic [7:0] EE_ADDR_MODE = 8'h06;
   localparam logic [7:0] EE_ADDR_SVID = 8'h08;
   localparam logic [7:0] EE_ADDR_SID = 8'h0A;
   localparam logic [7:0] EE_ADDR_CAP = 8'h0C;
   localparam logic [7:0] EE_ADDR_STEP = 8'h02;

   // ----------------------------------------
   // field positions inside word 06h
   // ----------------------------------------
   localparam int W06_EXT_VC = 0;
   localparam int W06_L0S_LO = 1;
   localparam int W06_L1_LO = 4;
   localparam int W06_CLK_PM = 7;
   localparam int W06_NO_ORD_EGR = 8;
   localparam int W06_NO_ORD_TAG = 9;
   localparam int W06_SF = 10;
   localparam int W06_CT_LO = 11;
   localparam int W06_ARB = 13;
   localparam int W06_CREDIT = 14;
   localparam int W06_NP_SF = 15;

   // ----------------------------------------
   // field positions inside word 0Ch
   // ----------------------------------------
   localparam int W0C_MPS_LO = 0;
   localparam int W0C_ASPM_LO = 2;
   localparam int W0C_RBER = 4;
   localparam int W0C_MSI_DIS = 5;
   localparam int W0C_PAR_DIS = 6;
   localparam int W0C_PM_DIS = 7;
   localparam int W0C_PPNP = 8;

   localparam int NUM_PORTS = 3;

   // ----------------------------------------
   // register map and fields
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_IDS = 8'h08;
   localparam logic [7:0] REG_SUBSYS = 8'h0C;
   localparam logic [7:0] REG_RAW = 8'h10;
   localparam logic [7:0] ADDR_WORD_MASK = 8'hFC;
   localparam int CTRL_RELOAD = 0;
   localparam int CTRL_SKIP = 1;
   localparam int ST_DONE = 0;
   localparam int ST_SIG_OK = 1;
   localparam int ST_SIG_BAD = 2;
   localparam int ST_BUSY = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   localparam logic CTRL_SKIP_RESET = 1'b0;

   // ----------------------------------------
   // carrier types
   // ----------------------------------------
   typedef struct packed {
      logic ext_vc_count;
      logic [2:0] l0s_exit_latency;
      logic [2:0] l1_exit_latency;
      logic clock_pm_cap;
      logic [1:0] max_payload_supported;
      logic [1:0] aspm_support;
      logic role_based_err_rpt;
      logic msi_cap_disable;
      logic compliance_parity_disable;
      logic pm_cap_disable;
      logic posted_pass_nonposted_enable;
   } port_cfg_t;

   typedef struct packed {
      logic no_order_egress;
      logic no_order_cpl_tag;
      logic store_forward;
      logic [1:0] cut_through_threshold;
      logic arbiter_mode;
      logic credit_update_mode;
      logic nonposted_sf_only;
   } switch_mode_t;

   typedef struct packed {
      logic [15:0] vendor_id;
      logic [15:0] device_id;
      logic [15:0] subsys_vendor_id;
      logic [15:0] subsys_id;
   } id_cfg_t;

   // hardware defaults; id values are arbitrary
   localparam port_cfg_t DEF_PORT_CFG = '0;
   localparam switch_mode_t DEF_SWITCH_MODE = '0;
   localparam id_cfg_t DEF_IDS = 64'h0000_0000_0000_0000;

endpackage

// >>> verif/eeprom_model.sv
// behavioural configuration eeprom answering held word requests
// assumes the loader's req/ack reader; slow adds five wait cycles
`timescale 1ns/10ps

module eeprom_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic slow,
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   input wire logic [15:0] words [7],
   output logic ee_ack,
   output logic [15:0] ee_rdata
);
   logic [2:0] wait_cnt;
   // word 0 holds the validity signature set by the bench
   wire [2:0] word_idx = ee_addr[3:1];
   wire answer = ee_req && !ee_ack && (!slow || wait_cnt == 3'h5);

   // data toggles outside an answer so a stale word never looks valid
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ee_ack <= 1'b0;
         ee_rdata <= 16'h0000;
         wait_cnt <= 3'h0;
      end else begin
         ee_ack <= answer;
         ee_rdata <= answer ? words[word_idx] : ~ee_rdata;
         wait_cnt <= (ee_req && !answer) ? wait_cnt + 3'h1 : 3'h0;
      end
   end
endmodule

// >>> verif/loader_assertions.sv
// checker for the configuration loader ports
// assumes a bind onto eeprom_config_loader, one clock domain
`timescale 1ns/10ps

module loader_checker
   import eeprom_loader_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ee_req,
   input wire logic [7:0] ee_addr,
   input wire logic ee_ack,
   input wire logic [15:0] ee_rdata,
   input id_cfg_t ids,
   input switch_mode_t port0_mode,
   input port_cfg_t port_cfg [NUM_PORTS],
   input wire logic cfg_access_enable
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // ----------------------------------------
   // helper: word taken at the previous edge
   // ----------------------------------------
   logic [15:0] last_data;
   wire take = ee_req && ee_ack;
   always_ff @(posedge aclk) begin
      last_data <= ee_rdata;
   end

   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_sig_first;
      $rose(aresetn) |-> ##[0:2] (ee_req && ee_addr == EE_ADDR_SIG);
   endproperty
   a_sig_first: assert property (p_sig_first) else $error("first read not signature");
   property p_bad_sig;
      take && ee_addr == EE_ADDR_SIG && ee_rdata != EE_SIGNATURE
         |=> (!ee_req && ids == DEF_IDS && port0_mode == DEF_SWITCH_MODE) [*3];
   endproperty
   a_bad_sig: assert property (p_bad_sig) else $error("reads went on after bad word");
   property p_vid;
      take && ee_addr == EE_ADDR_VID |=> ids.vendor_id == last_data;
   endproperty
   a_vid: assert property (p_vid) else $error("vendor id not loaded");
   property p_sid;
      take && ee_addr == EE_ADDR_SID |=> ids.subsys_id == last_data;
   endproperty
   a_sid: assert property (p_sid) else $error("subsystem id not loaded");
   property p_mode;
      take && ee_addr == EE_ADDR_MODE |=> port_cfg[0].l0s_exit_latency == last_data[3:1]
         && port_cfg[1].l1_exit_latency == last_data[6:4]
         && port0_mode.cut_through_threshold == last_data[12:11];
   endproperty
   a_mode: assert property (p_mode) else $error("mode word fields wrong");
   property p_cap;
      take && ee_addr == EE_ADDR_CAP |=> (port_cfg[2].max_payload_supported == last_data[1:0]
         && port_cfg[1].posted_pass_nonposted_enable == last_data[8]) ##[0:1] cfg_access_enable;
   endproperty
   a_cap: assert property (p_cap) else $error("capability word fields wrong");
   property p_ports_same;
      cfg_access_enable |-> port_cfg[1] == port_cfg[0] && port_cfg[2] == port_cfg[0];
   endproperty
   a_ports_same: assert property (p_ports_same) else $error("ports differ");
   property p_no_access;
      ee_req |-> !cfg_access_enable;
   endproperty
   a_no_access: assert property (p_no_access) else $error("access open while loading");

   // main scenarios
   c_full_load: cover property (take && ee_addr == EE_ADDR_CAP);
   c_bad_sig: cover property (take && ee_addr == EE_ADDR_SIG && ee_rdata != EE_SIGNATURE);
   c_slow_ack: cover property ((ee_req && !ee_ack) [*4]);
endmodule

bind eeprom_config_loader loader_checker u_chk (
   .aclk(aclk),
   .aresetn(aresetn),
   .ee_req(ee_req),
   .ee_addr(ee_addr),
   .ee_ack(ee_ack),
   .ee_rdata(ee_rdata),
   .ids(ids),
   .port0_mode(port0_mode),
   .port_cfg(port_cfg),
   .cfg_access_enable(cfg_access_enable)
);

// >>> verif/testbench.sv
// self-checking bench for the configuration loader
// assumes the eeprom model beside it and an axi4-lite master here
`timescale 1ns/10ps

module testbench
   import eeprom_loader_pkg::*;
();
   logic aclk, aresetn, slow, ee_req, ee_ack, cfg_access_enable;
   logic [7:0] ee_addr, s_axi_awaddr, s_axi_araddr;
   logic [15:0] ee_rdata;
   logic [15:0] ee_words [7];
   id_cfg_t ids;
   switch_mode_t port0_mode;
   port_cfg_t port_cfg [NUM_PORTS];
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   int n_fail = 0;
   int num_checks = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h0000_7db6;
   int unsigned wq[$];

   eeprom_config_loader uut (.aclk(aclk), .aresetn(aresetn), .ee_req(ee_req),
      .ee_addr(ee_addr), .ee_ack(ee_ack), .ee_rdata(ee_rdata), .ids(ids),
      .port0_mode(port0_mode), .port_cfg(port_cfg), .cfg_access_enable(cfg_access_enable),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   eeprom_model eemod (.aclk(aclk), .aresetn(aresetn), .slow(slow), .ee_req(ee_req),
      .ee_addr(ee_addr), .words(ee_words), .ee_ack(ee_ack), .ee_rdata(ee_rdata));

   // ----------------------------------------
   // clock and hang guard
   // ----------------------------------------
   initial begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_fail = n_fail + 1;
         finish_test();
      end
   end

   // ----------------------------------------
   // helpers and reference model
   // ----------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   function automatic port_cfg_t exp_port(input int unsigned m, input int unsigned c);
      port_cfg_t p;
      p.ext_vc_count = m[0];
      p.l0s_exit_latency = m[3:1];
      p.l1_exit_latency = m[6:4];
      p.clock_pm_cap = m[7];
      p.max_payload_supported = c[1:0];
      p.aspm_support = c[3:2];
      p.role_based_err_rpt = c[4];
      p.msi_cap_disable = c[5];
      p.compliance_parity_disable = c[6];
      p.pm_cap_disable = c[7];
      p.posted_pass_nonposted_enable = c[8];
      return p;
   endfunction
   function automatic switch_mode_t exp_mode(input int unsigned m);
      switch_mode_t s;
      s.no_order_egress = m[8];
      s.no_order_cpl_tag = m[9];
      s.store_forward = m[10];
      s.cut_through_threshold = m[12:11];
      s.arbiter_mode = m[13];
      s.credit_update_mode = m[14];
      s.nonposted_sf_only = m[15];
      return s;
   endfunction
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // ----------------------------------------
   // axi4-lite master
   // ----------------------------------------
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awready && !aw) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wready && !w) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge aclk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   // ----------------------------------------
   // scenario steps
   // ----------------------------------------
   task automatic new_words(input logic bad);
      wq.delete();
      seed = next_rand(seed);
      wq.push_back(bad ? 32'h0000_1516 ^ ((seed & 32'h0000_FFFF) | 1) : 32'h0000_1516);
      ee_words[0] <= 16'(wq[0]);
      for (int i = 1; i < 7; i++) begin
         seed = next_rand(seed);
         wq.push_back(seed & 32'h0000_FFFF);
         ee_words[i] <= 16'(wq[i]);
      end
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (cfg_access_enable !== 1'b0 && n < 50) begin
         @(posedge aclk);
         n++;
      end
      while (cfg_access_enable !== 1'b1 && n < 2000) begin
         @(posedge aclk);
         n++;
      end
      check(64'(cfg_access_enable), 64'(1'b1));
   endtask
   task automatic verify();
      logic good;
      port_cfg_t ep, g;
      switch_mode_t em;
      good = (wq[0] == 32'h0000_1516);
      ep = good ? exp_port(wq[3], wq[6]) : DEF_PORT_CFG;
      em = good ? exp_mode(wq[3]) : DEF_SWITCH_MODE;
      check(64'(ids), good ? {16'(wq[1]), 16'(wq[2]), 16'(wq[4]), 16'(wq[5])} : DEF_IDS);
      for (int i = 0; i < NUM_PORTS; i++) begin
         g = port_cfg[i];
         check(64'(g[16:9]), 64'(ep[16:9]));
         check(64'(g[8:5]), 64'(ep[8:5]));
         check(64'(g[4:0]), 64'(ep[4:0]));
      end
      check(64'(port0_mode[7:5]), 64'(em[7:5]));
      check(64'(port0_mode[4:0]), 64'(em[4:0]));
      axi_read(REG_STATUS, rd, resp);
      check(64'(rd), good ? 64'h0000_0000_0000_0003 : 64'h0000_0000_0000_0005);
      axi_read(REG_IDS, rd, resp);
      check(64'(rd), good ? 64'({16'(wq[2]), 16'(wq[1])}) : 64'h0000_0000_0000_0000);
      axi_read(REG_RAW, rd, resp);
      check(64'(rd), good ? 64'({16'(wq[6]), 16'(wq[3])}) : 64'h0);
   endtask

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      aresetn = 1'b0;
      slow = 1'b0;
      s_axi_awaddr = 8'h00;
      s_axi_awvalid = 1'b0;
      s_axi_wdata = 32'h0000_0000;
      s_axi_wstrb = 4'hF;
      s_axi_wvalid = 1'b0;
      s_axi_bready = 1'b0;
      s_axi_araddr = 8'h00;
      s_axi_arvalid = 1'b0;
      s_axi_rready = 1'b0;
      new_words(1'b0);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      wait_done();
      verify();
      axi_read(8'h20, rd, resp);
      check(64'({resp, rd}), 64'({RESP_SLVERR, 32'h0000_0000}));
      axi_write(8'h24, 32'hFFFF_FFFF, resp);
      check(64'(resp), 64'(RESP_SLVERR));
      // reloads with fresh words, slow and prompt answers, one bad signature
      for (int k = 0; k < 6; k++) begin
         new_words(k == 2);
         slow <= k[0];
         axi_write(REG_CTRL, 32'h0000_0001, resp);
         check(64'(resp), 64'(RESP_OKAY));
         wait_done();
         verify();
      end
      // skip set: reload clears fields and reads nothing
      axi_write(REG_CTRL, 32'h0000_0003, resp);
      axi_read(REG_CTRL, rd, resp);
      check(64'({rd[1:0], cfg_access_enable}), 64'(3'b101));
      check(64'(ids), 64'(DEF_IDS));
      finish_test();
   end
endmodule
